/* timer_defines.svh */
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFF_CTRL 8'h00
`define OFF_LOW 8'h04
`define OFF_HIGH 8'h08
`define OFF_IRQ_STAT 8'h0C
`define OFF_IRQ_CLR 8'h10
`define OFF_IRQ_EN 8'h14
// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define CTRL_MODE_MSB 7
`define CTRL_MODE_LSB 6
`define CTRL_UNUSED_BIT 5
`define CTRL_RUN_BIT 4
`define CTRL_EDGE_BIT 3
`define CTRL_DIV_MSB 2
`define CTRL_DIV_LSB 0
`define CTRL_RESET 8'h08
`define BYTE_RESET 8'h00
`define MODE_UNUSED 2'h0
`define MODE_EVENT 2'h1
`define MODE_TIMER 2'h2
`define MODE_PULSE 2'h3
`define COUNT_FULL 16'hFFFF
// ----------------------------------------
// interrupt bits and bus answers
// ----------------------------------------
`define IRQ_OVF_BIT 0
`define IRQ_PW_BIT 1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* timer_pkg.sv */
package timer_pkg;
  // control register layout
  typedef struct packed {
    logic [1:0] mode;
    logic unused;
    logic run;
    logic edge_pol;
    logic [2:0] div_sel;
  } ctrl_t;
  // timing strobes from the count source
  typedef struct packed {
    logic div_tick;
    logic pin_rise;
    logic pin_fall;
  } src_t;
  // pulse width measurement states
  typedef enum logic [0:0] {
    st_wait,
    st_measure
  } pw_state_t;
endpackage

/* count_source.sv */
`timescale 1ns/1ps
module count_source #(
  parameter int DIV_W = 7
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // prescaler tick and divide select
  input wire logic psc_tick,
  input wire logic [2:0] div_sel,
  // external event pin
  input wire logic event_input_pin,
  // strobes out
  output timer_pkg::src_t src
);
  logic [DIV_W-1:0] div_cnt_q, div_cnt_d;
  logic sync1_q, sync2_q, prev_q;
  logic [DIV_W-1:0] mask;

  // divider mask of 2^sel - 1
  always_comb begin
    mask = DIV_W'((1 << div_sel) - 1);
    div_cnt_d = psc_tick ? div_cnt_q + 1'b1 : div_cnt_q;
  end

  // divider counter and two-stage pin synchroniser
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      div_cnt_q <= '0;
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      sync1_q <= event_input_pin;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // divided tick and edges seen only after synchronising
  always_comb begin
    src.div_tick = psc_tick && ((div_cnt_q & mask) == mask);
    src.pin_rise = sync2_q && !prev_q;
    src.pin_fall = !sync2_q && prev_q;
  end
endmodule

/* event_timer.sv */
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "timer_defines.svh"
module event_timer (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // time base and event pin
  input wire logic psc_tick,
  input wire logic event_input_pin,
  // interrupt
  output logic irq
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  timer_pkg::ctrl_t ctrl_q, ctrl_d;
  timer_pkg::src_t src;
  timer_pkg::pw_state_t pw_q, pw_d;
  logic [15:0] count_q, count_d, preload_q, preload_d;
  logic [7:0] lowbuf_q, lowbuf_d;
  logic [1:0] stat_q, stat_d, en_q, en_d;
  logic irq_q, irq_d;
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [7:0] waddr_q, waddr_d;
  logic [7:0] wbyte_q, wbyte_d;
  logic wstrb0_q, wstrb0_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic do_write, ar_take, inc, full;
  logic ctrl_wr, lo_wr, hi_wr, clr_wr, en_wr, lo_rd, hi_rd;
  logic start_edge, stop_edge, pw_done;

  count_source #(
    .DIV_W(7)
  ) u_src (
    .mclk(mclk),
    .resetn(resetn),
    .psc_tick(psc_tick),
    .div_sel(ctrl_q.div_sel),
    .event_input_pin(event_input_pin),
    .src(src)
  );

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  // write channel capture, decode and response
  always_comb begin
    aw_held_d = aw_held_q | (s_axi_awvalid & awready_q);
    w_held_d = w_held_q | (s_axi_wvalid & wready_q);
    waddr_d = (s_axi_awvalid & awready_q) ? s_axi_awaddr : waddr_q;
    wbyte_d = (s_axi_wvalid & wready_q) ? s_axi_wdata[7:0] : wbyte_q;
    wstrb0_d = (s_axi_wvalid & wready_q) ? s_axi_wstrb[0] : wstrb0_q;
    do_write = aw_held_q & w_held_q & !bvalid_q;
    bvalid_d = bvalid_q & !s_axi_bready;
    bresp_d = bresp_q;
    ctrl_wr = 1'b0;
    lo_wr = 1'b0;
    hi_wr = 1'b0;
    clr_wr = 1'b0;
    en_wr = 1'b0;
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `RESP_OKAY;
      unique case (waddr_q)
        `OFF_CTRL: ctrl_wr = wstrb0_q;
        `OFF_LOW: lo_wr = wstrb0_q;
        `OFF_HIGH: hi_wr = wstrb0_q;
        `OFF_IRQ_CLR: clr_wr = wstrb0_q;
        `OFF_IRQ_EN: en_wr = wstrb0_q;
        `OFF_IRQ_STAT: bresp_d = `RESP_OKAY; // read only, write ignored
        default: bresp_d = `RESP_SLVERR;
      endcase
    end
    awready_d = !aw_held_d & !bvalid_d;
    wready_d = !w_held_d & !bvalid_d;
  end

  // read channel, one cycle answer
  always_comb begin
    ar_take = s_axi_arvalid & arready_q;
    rvalid_d = rvalid_q & !s_axi_rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    lo_rd = 1'b0;
    hi_rd = 1'b0;
    if (ar_take) begin
      rvalid_d = 1'b1;
      rresp_d = `RESP_OKAY;
      rdata_d = '0;
      unique case (s_axi_araddr)
        `OFF_CTRL: rdata_d[7:0] = {ctrl_q[7:6], 1'b0, ctrl_q[4:0]};
        `OFF_LOW: begin
          rdata_d[7:0] = lowbuf_q;
          lo_rd = 1'b1;
        end
        `OFF_HIGH: begin
          rdata_d[7:0] = count_q[15:8];
          hi_rd = 1'b1;
        end
        `OFF_IRQ_STAT: rdata_d[1:0] = stat_q;
        `OFF_IRQ_EN: rdata_d[1:0] = en_q;
        `OFF_IRQ_CLR: rdata_d = '0;
        default: rresp_d = `RESP_SLVERR;
      endcase
    end
    arready_d = !rvalid_d;
  end

  // bus registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_q <= 8'h00;
      wbyte_q <= 8'h00;
      wstrb0_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h00000000;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      waddr_q <= waddr_d;
      wbyte_q <= wbyte_d;
      wstrb0_q <= wstrb0_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // counter core
  // ----------------------------------------
  // increment source per mode, pulse width sequencing
  always_comb begin
    start_edge = ctrl_q.edge_pol ? src.pin_rise : src.pin_fall;
    stop_edge = ctrl_q.edge_pol ? src.pin_fall : src.pin_rise;
    pw_d = pw_q;
    pw_done = 1'b0;
    if (!ctrl_q.run || ctrl_q.mode != `MODE_PULSE) begin
      pw_d = timer_pkg::st_wait;
    end else begin
      unique case (pw_q)
        timer_pkg::st_wait: if (start_edge) pw_d = timer_pkg::st_measure;
        timer_pkg::st_measure: if (stop_edge) begin
          pw_d = timer_pkg::st_wait;
          pw_done = 1'b1;
        end
      endcase
    end
    unique case (ctrl_q.mode)
      `MODE_TIMER: inc = ctrl_q.run & src.div_tick;
      `MODE_EVENT: inc = ctrl_q.run & (ctrl_q.edge_pol ? src.pin_fall : src.pin_rise);
      `MODE_PULSE: inc = ctrl_q.run & (pw_q == timer_pkg::st_measure) & src.div_tick;
      default: inc = 1'b0;
    endcase
    full = inc & (count_q == `COUNT_FULL);
  end

  // register writes, byte buffer, counter and interrupt next values
  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_wr) begin
      ctrl_d = timer_pkg::ctrl_t'(wbyte_q);
      ctrl_d.unused = 1'b0;
    end else if (pw_done) begin
      ctrl_d.run = 1'b0;
    end
    lowbuf_d = lowbuf_q;
    if (lo_wr) lowbuf_d = wbyte_q;
    if (hi_rd) lowbuf_d = count_q[7:0];
    preload_d = hi_wr ? {wbyte_q, lowbuf_q} : preload_q;
    count_d = count_q;
    if (hi_wr && !ctrl_q.run) count_d = {wbyte_q, lowbuf_q};
    else if (full) count_d = preload_q;
    else if (inc) count_d = count_q + 16'h0001;
    en_d = en_wr ? wbyte_q[1:0] : en_q;
    stat_d = clr_wr ? (stat_q & ~wbyte_q[1:0]) : stat_q;
    stat_d[`IRQ_OVF_BIT] = stat_d[`IRQ_OVF_BIT] | full;
    stat_d[`IRQ_PW_BIT] = stat_d[`IRQ_PW_BIT] | pw_done;
    irq_d = |(stat_d & en_d);
  end

  // core registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ctrl_q <= timer_pkg::ctrl_t'(`CTRL_RESET);
      pw_q <= timer_pkg::st_wait;
      count_q <= {`BYTE_RESET, `BYTE_RESET};
      preload_q <= {`BYTE_RESET, `BYTE_RESET};
      lowbuf_q <= `BYTE_RESET;
      stat_q <= 2'h0;
      en_q <= 2'h0;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      pw_q <= pw_d;
      count_q <= count_d;
      preload_q <= preload_d;
      lowbuf_q <= lowbuf_d;
      stat_q <= stat_d;
      en_q <= en_d;
      irq_q <= irq_d;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign irq = irq_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_wrap;
    inc && count_q == 16'hFFFF && !(hi_wr && !ctrl_q.run);
  endsequence
  sequence s_reloaded;
    count_q == $past(preload_q) && stat_q[0];
  endsequence
  property p_overflow_reload;
    s_wrap |=> s_reloaded;
  endproperty
  a_overflow_reload: assert property (p_overflow_reload) else $error("no reload on overflow");

  property p_count_up;
    inc && count_q != 16'hFFFF && !hi_wr |=> count_q == $past(count_q) + 16'h0001;
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter did not step by one");

  property p_load_stopped;
    hi_wr && !ctrl_q.run |=> count_q == {$past(wbyte_q), $past(lowbuf_q)} && preload_q == count_q;
  endproperty
  a_load_stopped: assert property (p_load_stopped) else $error("stopped load missed");

  property p_load_running;
    hi_wr && ctrl_q.run && !inc |=> count_q == $past(count_q);
  endproperty
  a_load_running: assert property (p_load_running) else $error("running counter disturbed");

  property p_low_write;
    lo_wr && !inc && !hi_rd |=> $stable(preload_q) && $stable(count_q)
      && lowbuf_q == $past(wbyte_q);
  endproperty
  a_low_write: assert property (p_low_write) else $error("low write reached counter");

  sequence s_hi_read;
    hi_rd ##1 (rvalid_q && lowbuf_q == $past(count_q[7:0]));
  endsequence
  property p_high_read;
    hi_rd |-> s_hi_read and (##1 rdata_q[7:0] == $past(count_q[15:8]));
  endproperty
  a_high_read: assert property (p_high_read) else $error("high read capture wrong");

  property p_low_read;
    lo_rd && !lo_wr |=> rdata_q == {24'h000000, lowbuf_q};
  endproperty
  a_low_read: assert property (p_low_read) else $error("low read not buffer");

  property p_ctrl_bit5;
    ar_take && s_axi_araddr == 8'h00 |=> !rdata_q[5] && !ctrl_q.unused;
  endproperty
  a_ctrl_bit5: assert property (p_ctrl_bit5) else $error("control bit 5 not zero");

  property p_event_edge;
    ctrl_q.mode == 2'h1 && ctrl_q.run && (ctrl_q.edge_pol ? src.pin_fall : src.pin_rise)
      |-> inc;
  endproperty
  a_event_edge: assert property (p_event_edge) else $error("event edge not counted");

  property p_pw_wait;
    ctrl_q.mode == 2'h3 && pw_q == timer_pkg::st_wait |-> !inc;
  endproperty
  a_pw_wait: assert property (p_pw_wait) else $error("counting before active edge");

  property p_div_one;
    ctrl_q.div_sel == 3'h0 && psc_tick |-> src.div_tick;
  endproperty
  a_div_one: assert property (p_div_one) else $error("undivided tick lost");

  property p_no_unused_count;
    ctrl_q.mode == 2'h0 |-> !inc;
  endproperty
  a_no_unused_count: assert property (p_no_unused_count) else $error("unused mode counts");
endmodule

/* pin_source.sv */
`timescale 1ns/1ps
module pin_source (
  // clock
  input wire logic mclk,
  // driven event pin
  output logic pin
);
  // ----------------------------------------
  // pin stimulus
  // ----------------------------------------
  initial pin = 1'b0;
  // change after an edge, then hold past the synchroniser and edge detect
  task automatic drive(input logic v);
    @(posedge mclk);
    pin <= v;
    repeat (6) @(posedge mclk);
  endtask
endmodule

/* tb_sixteen_bit_event_timer.sv */
`timescale 1ns/1ps
`include "timer_defines.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb_sixteen_bit_event_timer;
  // ----------------------------------------
  // clock, reset and bus signals
  // ----------------------------------------
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] awaddr;
  logic [7:0] araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic psc_tick;
  logic pin;
  logic [31:0] d;
  logic [1:0] r;
  int n_fail = 0;
  int compares = 0;

  // free running clock
  always #20 mclk = ~mclk;

  // ----------------------------------------
  // design and pin source
  // ----------------------------------------
  event_timer u_dut (
    .mclk(mclk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .psc_tick(psc_tick), .event_input_pin(pin), .irq(irq)
  );
  pin_source u_src (.mclk(mclk), .pin(pin));

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  // write one byte register, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [3:0] s = 4'hF);
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    `CHK(bresp, `RESP_OKAY)
    bready <= 1'b0;
  endtask
  // read one register word and its response
  task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rv);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    dv = rdata;
    rv = rresp;
    rready <= 1'b0;
  endtask
  // read and compare a byte register
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] dv;
    logic [1:0] rv;
    rd(a, dv, rv);
    `CHK({rv, dv}, {`RESP_OKAY, 24'h0, e})
  endtask
  // coherent 16-bit read: high first, then buffered low
  task automatic c16(input logic [15:0] e);
    rc(`OFF_HIGH, e[15:8]);
    rc(`OFF_LOW, e[7:0]);
  endtask
  // stop the counter and load a preload through the low byte buffer
  task automatic load(input logic [15:0] v);
    wr(`OFF_CTRL, `CTRL_RESET);
    wr(`OFF_LOW, v[7:0]);
    wr(`OFF_HIGH, v[15:8]);
  endtask
  // prescaler pulses, one every two clocks
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge mclk);
      psc_tick <= 1'b1;
      @(posedge mclk);
      psc_tick <= 1'b0;
    end
  endtask

  // ----------------------------------------
  // verdict and watchdog
  // ----------------------------------------
  task automatic summarize;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // cut a hang well past the expected run of some two thousand cycles
  initial begin
    repeat (50000) @(posedge mclk);
    n_fail++;
    summarize;
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    // idle bus and time base while reset is held
    awaddr <= 8'h00;
    araddr <= 8'h00;
    wdata <= 32'h00000000;
    wstrb <= 4'h0;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    arvalid <= 1'b0;
    rready <= 1'b0;
    psc_tick <= 1'b0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    // reset values, field layout, strobe and unmapped access
    rc(`OFF_CTRL, `CTRL_RESET);
    c16(16'h0000);
    wr(`OFF_CTRL, 8'hFF, 4'h0);
    rc(`OFF_CTRL, `CTRL_RESET);
    wr(`OFF_CTRL, 8'hFF);
    rc(`OFF_CTRL, 8'hDF);
    wr(`OFF_CTRL, `CTRL_RESET);
    rd(8'h18, d, r);
    `CHK({r, d}, {`RESP_SLVERR, 32'h0})
    wr(`OFF_IRQ_STAT, 8'hFF);
    rc(`OFF_IRQ_STAT, 8'h00);
    $display("test registers done");
    // byte buffer and preload while stopped
    wr(`OFF_LOW, 8'h34);
    c16(16'h0000);
    wr(`OFF_LOW, 8'h34);
    wr(`OFF_HIGH, 8'h12);
    c16(16'h1234);
    wr(`OFF_LOW, 8'h56);
    rc(`OFF_LOW, 8'h56);
    c16(16'h1234);
    $display("test byte access done");
    // timer mode, every divide select counts two divided ticks
    for (int s = 0; s < 8; s++) begin
      load(16'h0000);
      wr(`OFF_CTRL, 8'h90 | 8'(s));
      tk(2 << s);
      c16(16'h0002);
    end
    // unused mode code never counts, even with run set
    load(16'h0000);
    wr(`OFF_CTRL, 8'h10);
    tk(2);
    c16(16'h0000);
    $display("test timer divide done");
    // overflow, reload, pending preload and interrupt
    load(16'hFFFE);
    wr(`OFF_IRQ_EN, 8'h01);
    wr(`OFF_CTRL, 8'h90);
    wr(`OFF_LOW, 8'h10);
    wr(`OFF_HIGH, 8'h00);
    c16(16'hFFFE);
    tk(1);
    c16(16'hFFFF);
    rc(`OFF_IRQ_STAT, 8'h00);
    tk(1);
    c16(16'h0010);
    rc(`OFF_IRQ_STAT, 8'h01);
    `CHK(irq, 1'b1)
    tk(1);
    c16(16'h0011);
    wr(`OFF_IRQ_EN, 8'h00);
    rc(`OFF_IRQ_STAT, 8'h01);
    `CHK(irq, 1'b0)
    wr(`OFF_IRQ_EN, 8'h01);
    rc(`OFF_IRQ_EN, 8'h01);
    `CHK(irq, 1'b1)
    wr(`OFF_IRQ_CLR, 8'h01);
    rc(`OFF_IRQ_STAT, 8'h00);
    `CHK(irq, 1'b0)
    $display("test overflow done");
    // event mode, rising edges then falling edges
    load(16'h0000);
    wr(`OFF_CTRL, 8'h50);
    u_src.drive(1'b1);
    u_src.drive(1'b0);
    u_src.drive(1'b1);
    u_src.drive(1'b0);
    c16(16'h0002);
    load(16'h0000);
    wr(`OFF_CTRL, 8'h58);
    u_src.drive(1'b1);
    u_src.drive(1'b0);
    u_src.drive(1'b1);
    c16(16'h0001);
    $display("test event done");
    // pulse width: armed, counts only inside the pulse, then self-stops
    u_src.drive(1'b0);
    load(16'h0000);
    wr(`OFF_CTRL, 8'hD8);
    tk(3);
    c16(16'h0000);
    u_src.drive(1'b1);
    tk(4);
    u_src.drive(1'b0);
    tk(3);
    c16(16'h0004);
    rc(`OFF_CTRL, 8'hC8);
    rc(`OFF_IRQ_STAT, 8'h02);
    wr(`OFF_IRQ_CLR, 8'h02);
    rc(`OFF_IRQ_STAT, 8'h00);
    // low pulse: edge select low starts on falling and stops on rising
    load(16'h0000);
    u_src.drive(1'b1);
    wr(`OFF_CTRL, 8'hD0);
    tk(2);
    c16(16'h0000);
    u_src.drive(1'b0);
    tk(2);
    u_src.drive(1'b1);
    tk(2);
    c16(16'h0002);
    rc(`OFF_CTRL, 8'hC0);
    rc(`OFF_IRQ_STAT, 8'h02);
    $display("test pulse width done");
    // reset with the counter stopped after a load brings control, low buffer, count and status back to their reset values
    load(16'h1234);
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    rc(`OFF_CTRL, `CTRL_RESET);
    rc(`OFF_LOW, `BYTE_RESET);
    c16(16'h0000);
    rc(`OFF_IRQ_STAT, 8'h00);
    `CHK(irq, 1'b0)
    $display("test reset done");
    summarize;
  end
endmodule
